/* File: rtl/gpp_defines.vh */
// Register map, field positions, reset values and timing counts of the pin port
// Functional notes
// - Toggle alias inverts driver-enable bits written one
// - Zero bits written to aliases change nothing
// - Toggle alias reads back driver-enable register
// - Drive level sets pin only when driven
// - Set alias forces drive-level bits high
// - Clear alias forces drive-level bits low
// - Toggle alias inverts drive-level bits
// - Set, clear, toggle aliases read drive level
// - Sampled register shows pin level when buffered
// - Writing ones to sampled register toggles drive
// - Disabled input buffer freezes sampled bit
// - Sense match sets the pin event flag
// - Writing one clears flag, zero keeps it
// - Port control bit zero limits slew portwide
// - Bit seven inverts pin input and output
// - Bit three pulls up input-only pins
// - Codes one/two/three: both, rising, falling edges
// - Code zero no event; four disables buffer
// - Code five low level; six, seven reserved
// - Pin controls at consecutive offsets from base
// - Driver-enable zero input-only, one drives pin
// - Three quiet cycles after a pin event
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH

`define GPP_AW 5
`define GPP_DW 8

// Register offsets
`define GPP_ADDR_DRV_EN 5'h00
`define GPP_ADDR_DRV_EN_SET 5'h01
`define GPP_ADDR_DRV_EN_CLR 5'h02
`define GPP_ADDR_DRV_EN_TGL 5'h03
`define GPP_ADDR_LVL 5'h04
`define GPP_ADDR_LVL_SET 5'h05
`define GPP_ADDR_LVL_CLR 5'h06
`define GPP_ADDR_LVL_TGL 5'h07
`define GPP_ADDR_SAMPLED 5'h08
`define GPP_ADDR_FLAGS 5'h09
`define GPP_ADDR_PORT_CTRL 5'h0a
`define GPP_ADDR_PIN_CTRL 5'h10
`define GPP_PIN_CTRL_STEP 5'h01

// Reset values
`define GPP_RST_REG 8'h00

// Field positions
`define GPP_SLEW_BIT 0
`define GPP_FLIP_BIT 7
`define GPP_PULL_BIT 3
`define GPP_SENSE_HI 2
`define GPP_SENSE_LO 0
`define GPP_PIN_CTRL_MASK 8'h8f

// Sense select codes
`define GPP_SENSE_OFF_BUF_ON 3'h0
`define GPP_SENSE_ANY_EDGE 3'h1
`define GPP_SENSE_RISE 3'h2
`define GPP_SENSE_FALL 3'h3
`define GPP_SENSE_BUF_OFF 3'h4
`define GPP_SENSE_LOW 3'h5

// Quiet time after an event, in peripheral clock cycles
`define GPP_DEAD_CYCLES 2'h3

`endif

/* File: rtl/gpp_port.v */
// Eight-pin port register file with pin drive, sampling and event flags
`timescale 1ns/1ps
`include "gpp_defines.vh"

module gpp_port #(
  parameter NPIN = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [`GPP_AW-1:0] addr,
  input wire [`GPP_DW-1:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [`GPP_DW-1:0] rdata_r,
  // Pins
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out_r,
  output reg [NPIN-1:0] pin_oe_r,
  output reg [NPIN-1:0] weak_high_enable_r,
  output reg slew_limit_enable_r,
  // Pin event summary
  output reg pin_event_r
);

  reg [NPIN-1:0] drv_en_r;
  reg [NPIN-1:0] drv_en_nxt;
  reg [NPIN-1:0] lvl_r;
  reg [NPIN-1:0] lvl_nxt;
  reg [NPIN-1:0] sampled_r;
  reg [NPIN-1:0] flags_r;
  reg [NPIN-1:0] flags_nxt;
  reg [`GPP_DW-1:0] port_ctrl_r;
  reg [`GPP_DW-1:0] pin_ctrl_r [0:NPIN-1];
  reg [1:0] dead_r;
  reg [NPIN-1:0] flip;
  reg [NPIN-1:0] buf_on;
  reg [NPIN-1:0] pull;
  reg [NPIN-1:0] flip_nxt;
  reg [NPIN-1:0] pull_nxt;
  reg [NPIN-1:0] pin_wr;
  reg [NPIN-1:0] in_val;
  reg [NPIN-1:0] hit;
  reg [NPIN-1:0] set_ev;
  reg [NPIN-1:0] clr_w;
  reg [2:0] sense;
  reg [`GPP_DW-1:0] rd_nxt;
  integer i;
  integer j;
  integer k;
  wire [31:0] addr_ext;

  // Address widened for compares against integer offsets
  assign addr_ext = {{(32-`GPP_AW){1'b0}}, addr};

  // Per-pin decode of control fields and the input path
  always @* begin
    sense = 3'h0;
    for (i = 0; i < NPIN; i = i + 1) begin
      flip[i] = pin_ctrl_r[i][`GPP_FLIP_BIT];
      pull[i] = pin_ctrl_r[i][`GPP_PULL_BIT];
      pin_wr[i] = wr_en && (addr_ext == `GPP_ADDR_PIN_CTRL + i * `GPP_PIN_CTRL_STEP);
      flip_nxt[i] = pin_wr[i] ? wdata[`GPP_FLIP_BIT] : flip[i];
      pull_nxt[i] = pin_wr[i] ? wdata[`GPP_PULL_BIT] : pull[i];
      sense = pin_ctrl_r[i][`GPP_SENSE_HI:`GPP_SENSE_LO];
      buf_on[i] = (sense != `GPP_SENSE_BUF_OFF);
      in_val[i] = pin_in[i] ^ flip[i];
      if (sense == `GPP_SENSE_ANY_EDGE) begin
        hit[i] = in_val[i] ^ sampled_r[i];
      end else if (sense == `GPP_SENSE_RISE) begin
        hit[i] = in_val[i] & ~sampled_r[i];
      end else if (sense == `GPP_SENSE_FALL) begin
        hit[i] = ~in_val[i] & sampled_r[i];
      end else if (sense == `GPP_SENSE_LOW) begin
        hit[i] = ~in_val[i];
      end else begin
        hit[i] = 1'b0;
      end
    end
  end

  // Events are held off during the quiet window after the last one
  always @* begin
    set_ev = (dead_r == 2'h0) ? hit : {NPIN{1'b0}};
    clr_w = (wr_en && addr == `GPP_ADDR_FLAGS) ? wdata[NPIN-1:0] : {NPIN{1'b0}};
    flags_nxt = (flags_r & ~clr_w) | set_ev;
  end

  // Driver-enable and drive-level updates from writes
  always @* begin
    drv_en_nxt = drv_en_r;
    lvl_nxt = lvl_r;
    if (wr_en) begin
      if (addr == `GPP_ADDR_DRV_EN) begin
        drv_en_nxt = wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_DRV_EN_SET) begin
        drv_en_nxt = drv_en_r | wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_DRV_EN_CLR) begin
        drv_en_nxt = drv_en_r & ~wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_DRV_EN_TGL) begin
        drv_en_nxt = drv_en_r ^ wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_LVL) begin
        lvl_nxt = wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_LVL_SET) begin
        lvl_nxt = lvl_r | wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_LVL_CLR) begin
        lvl_nxt = lvl_r & ~wdata[NPIN-1:0];
      end else if (addr == `GPP_ADDR_LVL_TGL || addr == `GPP_ADDR_SAMPLED) begin
        lvl_nxt = lvl_r ^ wdata[NPIN-1:0];
      end
    end
  end

  // Read multiplexer, answered in the following cycle
  always @* begin
    rd_nxt = `GPP_RST_REG;
    if (addr == `GPP_ADDR_DRV_EN || addr == `GPP_ADDR_DRV_EN_SET ||
        addr == `GPP_ADDR_DRV_EN_CLR || addr == `GPP_ADDR_DRV_EN_TGL) begin
      rd_nxt = drv_en_r;
    end else if (addr == `GPP_ADDR_LVL || addr == `GPP_ADDR_LVL_SET ||
                 addr == `GPP_ADDR_LVL_CLR || addr == `GPP_ADDR_LVL_TGL) begin
      rd_nxt = lvl_r;
    end else if (addr == `GPP_ADDR_SAMPLED) begin
      rd_nxt = sampled_r;
    end else if (addr == `GPP_ADDR_FLAGS) begin
      rd_nxt = flags_r;
    end else if (addr == `GPP_ADDR_PORT_CTRL) begin
      rd_nxt = port_ctrl_r & 8'h01;
    end else begin
      // Pin control bytes, one per pin
      for (k = 0; k < NPIN; k = k + 1) begin
        if (addr_ext == `GPP_ADDR_PIN_CTRL + k * `GPP_PIN_CTRL_STEP) begin
          rd_nxt = pin_ctrl_r[k];
        end
      end
    end
  end

  // Register state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_en_r <= {NPIN{1'b0}};
      lvl_r <= {NPIN{1'b0}};
      sampled_r <= {NPIN{1'b0}};
      flags_r <= {NPIN{1'b0}};
      port_ctrl_r <= `GPP_RST_REG;
      dead_r <= 2'h0;
      rdata_r <= `GPP_RST_REG;
      for (j = 0; j < NPIN; j = j + 1) begin
        pin_ctrl_r[j] <= `GPP_RST_REG;
      end
    end else begin
      drv_en_r <= drv_en_nxt;
      lvl_r <= lvl_nxt;
      flags_r <= flags_nxt;
      // Only buffered pins follow the pin; others hold
      sampled_r <= (in_val & buf_on) | (sampled_r & ~buf_on);
      if (|set_ev) begin
        dead_r <= `GPP_DEAD_CYCLES;
      end else if (dead_r != 2'h0) begin
        dead_r <= dead_r - 2'h1;
      end
      if (wr_en && addr == `GPP_ADDR_PORT_CTRL) begin
        port_ctrl_r <= wdata & 8'h01;
      end
      for (j = 0; j < NPIN; j = j + 1) begin
        if (pin_wr[j]) begin
          pin_ctrl_r[j] <= wdata & `GPP_PIN_CTRL_MASK;
        end
      end
      rdata_r <= rd_en ? rd_nxt : `GPP_RST_REG;
    end
  end

  // Pin drive, registered from the next state; slew limit from the current port_ctrl_r
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_r <= {NPIN{1'b0}};
      pin_oe_r <= {NPIN{1'b0}};
      weak_high_enable_r <= {NPIN{1'b0}};
      slew_limit_enable_r <= 1'b0;
      pin_event_r <= 1'b0;
    end else begin
      pin_out_r <= lvl_nxt ^ flip_nxt;
      pin_oe_r <= drv_en_nxt;
      weak_high_enable_r <= pull_nxt & ~drv_en_nxt;
      slew_limit_enable_r <= port_ctrl_r[`GPP_SLEW_BIT];
      pin_event_r <= |flags_nxt;
    end
  end

endmodule

/* File: tb/gpp_pins.sv */
// Far-side pin model: resolves each pad level
`timescale 1ns/1ps
module gpp_pins (
  // Port drive and external level
  input wire [7:0] out,
  input wire [7:0] oe,
  input wire [7:0] pull,
  input wire [7:0] ext,
  // Resolved pad level
  output wire [7:0] lvl
);
  // Driver wins, else pull-up, else outside level
  assign lvl = (oe & out) | (~oe & pull) | (~oe & ~pull & ext);
endmodule

/* File: tb/gpp_port_sva.sv */
// Port-level assertions for the pin port
`timescale 1ns/1ps
module gpp_port_sva #(
  parameter NPIN = 8
) (
  // Clock, reset, register port
  input wire clk,
  input wire rst,
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata_r,
  // Pin side
  input wire [NPIN-1:0] pin_out_r,
  input wire [NPIN-1:0] pin_oe_r,
  input wire [NPIN-1:0] weak_high_enable_r,
  input wire slew_limit_enable_r,
  input wire pin_event_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Event seen, then all flags cleared next cycle
  sequence s_evt_clr;
    $rose(pin_event_r) ##1 (wr_en && addr == 5'h09 && wdata == 8'hff);
  endsequence
  a_oe_toggle: assert property (wr_en && addr == 5'h03 |=>
    pin_oe_r == ($past(pin_oe_r) ^ $past(wdata))) else $error("oe toggle");
  a_lvl_toggle: assert property (wr_en && (addr == 5'h07 || addr == 5'h08) |=>
    pin_out_r == ($past(pin_out_r) ^ $past(wdata))) else $error("level toggle");
  a_zero_keep: assert property (wr_en && wdata == 8'h00 &&
    addr inside {5'h03, 5'h05, 5'h06, 5'h07} |=> $stable(pin_out_r) && $stable(pin_oe_r))
    else $error("zero write changed");
  a_oe_hold: assert property (!(wr_en && addr <= 5'h03) |=> $stable(pin_oe_r))
    else $error("oe moved");
  a_slew_follow: assert property (wr_en && addr == 5'h0a |->
    ##2 slew_limit_enable_r == $past(wdata[0], 2)) else $error("slew");
  a_tgl_read: assert property (rd_en && addr == 5'h03 |=>
    rdata_r == $past(pin_oe_r)) else $error("toggle read");
  a_pull_input: assert property (!(|(weak_high_enable_r & pin_oe_r)))
    else $error("pull on driven pin");
  a_dead_time: assert property (s_evt_clr |=> !pin_event_r [*2])
    else $error("event in quiet time");
endmodule
bind gpp_port gpp_port_sva #(.NPIN(NPIN)) u_sva (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r), .pin_out_r(pin_out_r),
  .pin_oe_r(pin_oe_r), .weak_high_enable_r(weak_high_enable_r),
  .slew_limit_enable_r(slew_limit_enable_r), .pin_event_r(pin_event_r));

/* File: tb/tb_top.sv */
// Register-level bench for the pin port
`timescale 1ns/1ps
module tb_top;
  reg clk = 0;
  reg rst = 1;
  reg [4:0] addr = 5'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 0;
  reg rd_en = 0;
  reg [7:0] ext = 8'h00;
  reg [5:0] rise_m = 6'b100110;
  reg [5:0] fall_m = 6'b101010;
  wire [7:0] rdata_r, pin_out_r, pin_oe_r, pull, lvl;
  wire slew, evt;
  integer error_cnt = 0, samples_checked = 0, cyc = 0, c;
  // Clock 40 MHz
  always #12.5 clk = ~clk;
  gpp_port #(.NPIN(8)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_r(rdata_r), .pin_in(lvl), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
    .weak_high_enable_r(pull), .slew_limit_enable_r(slew), .pin_event_r(evt));
  gpp_pins u_pins (.out(pin_out_r), .oe(pin_oe_r), .pull(pull), .ext(ext), .lvl(lvl));
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk) wr_en <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk) rd_en <= 1'b0;
      @(negedge clk) chk(rdata_r, exp);
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (c = 3; c < 11; c = c + 1)
      rd(c[4:0], 8'h00);
    // Driver enable and aliases
    wr(5'h03, 8'h0f);
    wr(5'h03, 8'h3c);
    wr(5'h03, 8'h00);
    rd(5'h03, 8'h33);
    chk(pin_oe_r, 8'h33);
    wr(5'h01, 8'h44);
    rd(5'h00, 8'h77);
    chk(pin_oe_r, 8'h77);
    wr(5'h02, 8'h44);
    rd(5'h02, 8'h33);
    wr(5'h00, 8'h33);
    rd(5'h01, 8'h33);
    // Drive level and aliases
    wr(5'h04, 8'ha5);
    wr(5'h05, 8'h0a);
    wr(5'h06, 8'h81);
    wr(5'h07, 8'h03);
    wr(5'h08, 8'h10);
    wr(5'h05, 8'h00);
    for (c = 5; c < 8; c = c + 1)
      rd(c[4:0], 8'h3d);
    chk(pin_out_r, 8'h3d);
    rd(5'h08, 8'h31);
    // Pull-up, flip, unused bits
    wr(5'h16, 8'h08);
    wr(5'h17, 8'hf8);
    rd(5'h17, 8'h88);
    chk(pull, 8'hc0);
    chk(pin_out_r, 8'hbd);
    rd(5'h08, 8'h71);
    // Buffer off holds sample
    wr(5'h16, 8'h0c);
    wr(5'h16, 8'h04);
    rd(5'h08, 8'h71);
    wr(5'h16, 8'h00);
    // Sense codes zero to five on pin two
    for (c = 0; c < 6; c = c + 1) begin
      wr(5'h12, c[7:0]);
      rd(5'h12, c[7:0]);
      wr(5'h09, 8'hff);
      @(posedge clk) ext <= 8'h04;
      rd(5'h09, rise_m[c] ? 8'h04 : 8'h00);
      wr(5'h09, 8'hff);
      @(posedge clk) ext <= 8'h00;
      wr(5'h09, 8'h00);
      rd(5'h09, fall_m[c] ? 8'h04 : 8'h00);
      wr(5'h12, 8'h00);
      wr(5'h09, 8'hff);
    end
    // Clear just after a level event
    wr(5'h12, 8'h05);
    wr(5'h09, 8'hff);
    @(posedge clk);
    while (evt !== 1'b1)
      @(posedge clk);
    addr <= 5'h09;
    wdata <= 8'hff;
    wr_en <= 1'b1;
    @(posedge clk) wr_en <= 1'b0;
    @(negedge clk) chk({7'h00, evt}, 8'h00);
    rd(5'h09, 8'h00);
    rd(5'h09, 8'h04);
    chk({7'h00, evt}, 8'h01);
    // Slew and unmapped places
    wr(5'h0a, 8'h01);
    rd(5'h0a, 8'h01);
    chk({7'h00, slew}, 8'h01);
    wr(5'h0b, 8'hff);
    rd(5'h0b, 8'h00);
    rd(5'h18, 8'h00);
    report_and_stop;
  end
endmodule
